// ===== design/clock_calendar_counters.v
// Clock and calendar counter chain with clocking buffer.
// Assumes osc_tick is a one-cycle pulse at 32.768 kHz on clk, and a
// serial front end drives the register port and buffer strobes.
//
// Function
// - Divide oscillator ticks down to 1024 Hz.
// - Fraction counter 0..1023, wrap gives 1 Hz.
// - Host may load fraction counter directly.
// - BCD seconds write clears the fraction counter, unless the same batch loads it.
// - Apply host offset in 1/1024 s steps.
// - Halt bit stops fraction and downstream counters.
// - BCD seconds 0..59 at 0x00 and 0x12.
// - BCD minutes 0..59 at 0x01 and 0x13.
// - BCD hours 0..23 at 0x02 and 0x14.
// - Flag updates of seconds, minutes, hours.
// - BCD day 1..month length at 0x04/0x16.
// - Automatic leap correction for years 01..99.
// - One-hot dow_onehot shifts with day at 0x03/0x15.
// - BCD month 1..12 at 0x05 and 0x17.
// - BCD year 0..99 at 0x06 and 0x18.
// - 33-bit binary seconds counter on 1 Hz.
// - Buffer moves all counters as one batch.
// - Select bit picks BCD or binary counters.
`timescale 1ns/100ps
`include "clock_calendar_defines.vh"

module clock_calendar_counters #(
   parameter OSC_DIV_N = `OSC_DIV
) (
   input  wire       clk,
   input  wire       nrst,
   input  wire       osc_tick,
   input  wire       count_halt,
   input  wire       counter_select_decimal,
   input  wire [7:0] frac_adjust_hi,
   input  wire [7:0] frac_adjust_lo,
   input  wire       frac_adjust_apply,
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       buffer_capture,
   input  wire       buffer_commit,
   output reg        sec_updated,
   output reg        min_updated,
   output reg        hour_updated
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function [3:0] addr_index;
      input [7:0] a;
      begin
         case (a)
            `ADDR_SS, `ADDR_SS_ALIAS:   addr_index = `IDX_SS;
            `ADDR_MM, `ADDR_MM_ALIAS:   addr_index = `IDX_MM;
            `ADDR_HH, `ADDR_HH_ALIAS:   addr_index = `IDX_HH;
            `ADDR_DOW, `ADDR_DOW_ALIAS: addr_index = `IDX_DOW;
            `ADDR_DD, `ADDR_DD_ALIAS:   addr_index = `IDX_DD;
            `ADDR_MO, `ADDR_MO_ALIAS:   addr_index = `IDX_MO;
            `ADDR_YY, `ADDR_YY_ALIAS:   addr_index = `IDX_YY;
            `ADDR_FRAC_LO:              addr_index = `IDX_FRAC_LO;
            `ADDR_FRAC_HI:              addr_index = `IDX_FRAC_HI;
            default:                    addr_index = `IDX_NONE;
         endcase
      end
   endfunction

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function is_leap;
      input [7:0] y;
      begin
         if (y == `BCD_ZERO)
            is_leap = 1'b0;
         else if (y[4] == 1'b0)
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                      (y[3:0] == 4'h8);
         else
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end
   endfunction

   function [7:0] month_days;
      input [7:0] m;
      input [7:0] y;
      begin
         case (m)
            8'h04, 8'h06, 8'h09, 8'h11: month_days = `DAYS_30;
            `FEB_BCD:
               month_days = is_leap(y) ? `DAYS_29 : `DAYS_28;
            default:                    month_days = `DAYS_31;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg  [4:0]  div_q;
   reg  [9:0]  frac_q;
   reg  [7:0]  ss_q;
   reg  [7:0]  mm_q;
   reg  [7:0]  hh_q;
   reg  [6:0]  dow_q;
   reg  [7:0]  dd_q;
   reg  [7:0]  mo_q;
   reg  [7:0]  yy_q;
   reg  [32:0] bin_q;
   reg  [7:0]  buf_q [0:`BUF_SLOTS-1];
   reg  [`BUF_SLOTS-1:0] wmask_q;
   wire [8*`BUF_SLOTS-1:0] snap_all;
   integer     k;

   reg  [9:0]  frac_d;
   reg  [7:0]  ss_d;
   reg  [7:0]  mm_d;
   reg  [7:0]  hh_d;
   reg  [6:0]  dow_d;
   reg  [7:0]  dd_d;
   reg  [7:0]  mo_d;
   reg  [7:0]  yy_d;
   reg  [32:0] bin_d;
   reg  [11:0] frac_sum;
   reg         c_sec;
   reg         c_min;
   reg         c_hour;
   reg         c_day;
   reg         c_mon;

   wire [3:0]  wr_idx = addr_index(reg_addr);
   wire [3:0]  rd_idx = addr_index(reg_addr);
   wire        run = ~count_halt;
   wire        tick_1024 = osc_tick &&
                           (div_q == OSC_DIV_N[4:0] - 5'd1);
   wire [9:0]  adj_ofs = {frac_adjust_hi[1:0], frac_adjust_lo};
   wire        bin_written = |wmask_q[`IDX_DD:0];

   // ------------------------------------------------------------
   // Oscillator divider
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         div_q <= 5'd0;
      end else if (osc_tick) begin
         if (tick_1024)
            div_q <= 5'd0;
         else
            div_q <= div_q + 5'd1;
      end
   end

   // ------------------------------------------------------------
   // Counter chain next values
   // ------------------------------------------------------------
   always @* begin
      frac_sum = {2'b00, frac_q};
      if (run) begin
         // step once per 1024 Hz tick
         if (tick_1024)
            frac_sum = frac_sum + 12'd1;
         if (frac_adjust_apply)
            frac_sum = frac_sum + {{2{adj_ofs[9]}}, adj_ofs};
      end
      frac_d = frac_sum[9:0];
      // wrap past 1023 gives the 1 Hz carry
      c_sec = run && (frac_sum[11:10] == 2'b01);

      ss_d = ss_q;
      mm_d = mm_q;
      hh_d = hh_q;
      dd_d = dd_q;
      mo_d = mo_q;
      yy_d = yy_q;
      dow_d = dow_q;
      c_min = 1'b0;
      c_hour = 1'b0;
      c_day = 1'b0;
      c_mon = 1'b0;

      if (c_sec) begin
         c_min = (ss_q == `SS_MAX);
         ss_d = c_min ? `BCD_ZERO : bcd_inc(ss_q);
      end
      if (c_min) begin
         c_hour = (mm_q == `MM_MAX);
         mm_d = c_hour ? `BCD_ZERO : bcd_inc(mm_q);
      end
      if (c_hour) begin
         hh_d = (hh_q == `HH_MAX) ? `BCD_ZERO : bcd_inc(hh_q);
         c_day = (hh_q == `HH_MAX);
      end
      if (c_day) begin
         c_mon = (dd_q >= month_days(mo_q, yy_q));
         dd_d = c_mon ? `DD_FIRST : bcd_inc(dd_q);
         // bit 6 wraps to bit 0
         dow_d = {dow_q[5:0], dow_q[6]};
      end
      if (c_mon) begin
         mo_d = (mo_q == `MO_MAX) ? `MO_FIRST : bcd_inc(mo_q);
         if (mo_q == `MO_MAX)
            yy_d = (yy_q == `YY_MAX) ? `BCD_ZERO : bcd_inc(yy_q);
      end

      bin_d = c_sec ? bin_q + 33'd1 : bin_q;

      // batch load of written slots; binary mode loads all of slots 0..4 once any of them is written
      if (buffer_commit) begin
         if (counter_select_decimal) begin
            if (wmask_q[`IDX_SS])  ss_d  = buf_q[`IDX_SS];
            if (wmask_q[`IDX_MM])  mm_d  = buf_q[`IDX_MM];
            if (wmask_q[`IDX_HH])  hh_d  = buf_q[`IDX_HH];
            if (wmask_q[`IDX_DOW]) dow_d = buf_q[`IDX_DOW][6:0];
            if (wmask_q[`IDX_DD])  dd_d  = buf_q[`IDX_DD];
            if (wmask_q[`IDX_MO])  mo_d  = buf_q[`IDX_MO];
            if (wmask_q[`IDX_YY])  yy_d  = buf_q[`IDX_YY];
            if (wmask_q[`IDX_SS])
               frac_d = 10'd0;
         end else if (bin_written) begin
            bin_d = {buf_q[4][0], buf_q[3], buf_q[2],
                     buf_q[1], buf_q[0]};
         end
         if (wmask_q[`IDX_FRAC_LO])
            frac_d[7:0] = buf_q[`IDX_FRAC_LO];
         if (wmask_q[`IDX_FRAC_HI])
            frac_d[9:8] = buf_q[`IDX_FRAC_HI][1:0];
      end
   end

   // ------------------------------------------------------------
   // Counter registers and update flags
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         frac_q <= 10'd0;
         ss_q <= `BCD_ZERO;
         mm_q <= `BCD_ZERO;
         hh_q <= `BCD_ZERO;
         dow_q <= `DOW_RESET;
         dd_q <= `DD_FIRST;
         mo_q <= `MO_FIRST;
         yy_q <= `BCD_ZERO;
         bin_q <= 33'd0;
         sec_updated <= 1'b0;
         min_updated <= 1'b0;
         hour_updated <= 1'b0;
      end else begin
         frac_q <= frac_d;
         ss_q <= ss_d;
         mm_q <= mm_d;
         hh_q <= hh_d;
         dow_q <= dow_d;
         dd_q <= dd_d;
         mo_q <= mo_d;
         yy_q <= yy_d;
         bin_q <= bin_d;
         sec_updated <= (ss_d != ss_q);
         min_updated <= (mm_d != mm_q);
         hour_updated <= (hh_d != hh_q);
      end
   end

   // ------------------------------------------------------------
   // Clocking buffer
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `BUF_SLOTS; g = g + 1) begin : g_buf
         reg [7:0] snap;
         always @* begin
            snap = 8'h00;
            if (counter_select_decimal) begin
               case (g)
                  0:       snap = ss_q;
                  1:       snap = mm_q;
                  2:       snap = hh_q;
                  3:       snap = {1'b0, dow_q};
                  4:       snap = dd_q;
                  5:       snap = mo_q;
                  6:       snap = yy_q;
                  7:       snap = frac_q[7:0];
                  default: snap = {6'd0, frac_q[9:8]};
               endcase
            end else begin
               case (g)
                  0:       snap = bin_q[7:0];
                  1:       snap = bin_q[15:8];
                  2:       snap = bin_q[23:16];
                  3:       snap = bin_q[31:24];
                  4:       snap = {7'd0, bin_q[32]};
                  7:       snap = frac_q[7:0];
                  8:       snap = {6'd0, frac_q[9:8]};
                  default: snap = 8'h00;
               endcase
            end
         end
         assign snap_all[g*8 +: 8] = snap;
      end
   endgenerate

   // ------------------------------------------------------------
   // Buffer slots and pending-write mask
   // ------------------------------------------------------------
   // whole set captured in one cycle, bar a slot the host writes then
   always @(posedge clk) begin
      if (!nrst) begin
         for (k = 0; k < `BUF_SLOTS; k = k + 1)
            buf_q[k] <= 8'h00;
         wmask_q <= {`BUF_SLOTS{1'b0}};
      end else begin
         for (k = 0; k < `BUF_SLOTS; k = k + 1) begin
            if (reg_wr && (wr_idx == k[3:0]))
               buf_q[k] <= reg_wdata;
            else if (buffer_capture)
               buf_q[k] <= snap_all[k*8 +: 8];
            // Write in a commit cycle stays pending
            if (reg_wr && (wr_idx == k[3:0]))
               wmask_q[k] <= 1'b1;
            else if (buffer_commit)
               wmask_q[k] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (rd_idx == `IDX_NONE)
            reg_rdata <= 8'h00;
         else
            reg_rdata <= buf_q[rd_idx];
      end
   end

endmodule // clock_calendar_counters

// ===== common/clock_calendar_defines.vh
// Constants for the clock and calendar counter chain.
// Assumes inclusion by bare name from the design file.
`ifndef CLOCK_CALENDAR_DEFINES_VH
`define CLOCK_CALENDAR_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_SS        8'h00
`define ADDR_MM        8'h01
`define ADDR_HH        8'h02
`define ADDR_DOW       8'h03
`define ADDR_DD        8'h04
`define ADDR_MO        8'h05
`define ADDR_YY        8'h06
`define ADDR_FRAC_LO   8'h10
`define ADDR_FRAC_HI   8'h11
`define ADDR_SS_ALIAS  8'h12
`define ADDR_MM_ALIAS  8'h13
`define ADDR_HH_ALIAS  8'h14
`define ADDR_DOW_ALIAS 8'h15
`define ADDR_DD_ALIAS  8'h16
`define ADDR_MO_ALIAS  8'h17
`define ADDR_YY_ALIAS  8'h18

// ---------------------------------------------------------------
// Buffer slot indices
// ---------------------------------------------------------------
`define IDX_SS      4'h0
`define IDX_MM      4'h1
`define IDX_HH      4'h2
`define IDX_DOW     4'h3
`define IDX_DD      4'h4
`define IDX_MO      4'h5
`define IDX_YY      4'h6
`define IDX_FRAC_LO 4'h7
`define IDX_FRAC_HI 4'h8
`define IDX_NONE    4'hF
`define BUF_SLOTS   9

// ---------------------------------------------------------------
// Counter limits and reset values
// ---------------------------------------------------------------
`define OSC_DIV       32
`define FRAC_MAX      10'h3FF
`define SS_MAX        8'h59
`define MM_MAX        8'h59
`define HH_MAX        8'h23
`define MO_MAX        8'h12
`define YY_MAX        8'h99
`define DD_FIRST      8'h01
`define MO_FIRST      8'h01
`define FEB_BCD       8'h02
`define DOW_RESET     7'h01
`define BCD_ZERO      8'h00
`define DAYS_28       8'h28
`define DAYS_29       8'h29
`define DAYS_30       8'h30
`define DAYS_31       8'h31

`endif

// ===== verif/osc_source.sv
// Oscillator tick source standing in for the crystal divider input.
// Assumes one clock; ticks stand still while en is low.
`timescale 1ns/100ps
module osc_source #(
   parameter PERIOD = 3
) (
   input  wire clk,
   input  wire nrst,
   input  wire en,
   output reg  osc_tick
);
   reg [7:0] cnt_q;

   // ---------
   // Pulse every PERIOD cycles
   // ---------
   always @(posedge clk) begin
      if (!nrst || !en) begin
         cnt_q    <= 8'h00;
         osc_tick <= 1'b0;
      end else begin
         cnt_q    <= (cnt_q == PERIOD - 1) ? 8'h00 : cnt_q + 8'h01;
         osc_tick <= (cnt_q == PERIOD - 1);
      end
   end
endmodule // osc_source

// ===== verif/clock_calendar_assertions.sv
// Port checker for the clock and calendar counter chain.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module clock_calendar_checker (
   input wire       clk,
   input wire       nrst,
   input wire       osc_tick,
   input wire       count_halt,
   input wire       buffer_commit,
   input wire       frac_adjust_apply,
   input wire       reg_rd,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_rdata,
   input wire       sec_updated,
   input wire       min_updated,
   input wire       hour_updated
);
   wire mapped = (reg_addr <= 8'h06) ||
                 (reg_addr >= 8'h10 && reg_addr <= 8'h18);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ---------
   // Properties
   // ---------
   chk_unmapped_zero: assert property (
      reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rdata_stands: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_count_cause: assert property (
      sec_updated && !$past(buffer_commit) && !$past(frac_adjust_apply)
         |-> $past(osc_tick) || $past(osc_tick, 2))
      else $error("seconds moved without a tick");
   chk_halt_freeze: assert property (
      $past(count_halt) && $past(count_halt, 2) && !$past(buffer_commit)
         |-> !(sec_updated || min_updated || hour_updated))
      else $error("update while halted");
   chk_min_after_sec: assert property (
      min_updated && !$past(buffer_commit) |-> sec_updated)
      else $error("minute update without seconds carry");
   chk_hour_after_min: assert property (
      hour_updated && !$past(buffer_commit) |-> min_updated)
      else $error("hour update without minutes carry");
   chk_pulse_single: assert property (
      sec_updated && !buffer_commit && !frac_adjust_apply
         |=> !sec_updated)
      else $error("seconds update longer than one cycle");
   chk_reset_clean: assert property (
      $rose(nrst) |-> reg_rdata == 8'h00 && !sec_updated)
      else $error("outputs not clear after reset");
endmodule // clock_calendar_checker

bind clock_calendar_counters clock_calendar_checker clock_calendar_checker_inst (
   .clk(clk), .nrst(nrst), .osc_tick(osc_tick), .count_halt(count_halt),
   .buffer_commit(buffer_commit), .frac_adjust_apply(frac_adjust_apply),
   .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .sec_updated(sec_updated),
   .min_updated(min_updated), .hour_updated(hour_updated));

// ===== verif/clock_calendar_counters_tb.sv
// Self-checking bench for the clock and calendar counter chain.
// Assumes osc_source drives osc_tick; reads checked through a queue.
`timescale 1ns/100ps
module clock_calendar_counters_tb;
   localparam DIV = 4;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg         osc_en = 1'b0;
   wire        osc_tick;
   reg         count_halt = 1'b0;
   reg         counter_select_decimal = 1'b1;
   reg  [7:0]  frac_adjust_hi = 8'h00;
   reg  [7:0]  frac_adjust_lo = 8'h00;
   reg         frac_adjust_apply = 1'b0;
   reg  [7:0]  reg_addr = 8'h00;
   reg         reg_wr = 1'b0;
   reg  [7:0]  reg_wdata = 8'h00;
   reg         reg_rd = 1'b0;
   wire [7:0]  reg_rdata;
   reg         buffer_capture = 1'b0;
   reg         buffer_commit = 1'b0;
   wire        sec_updated;
   wire        min_updated;
   wire        hour_updated;
   reg         rd_seen = 1'b0;
   reg  [7:0]  exp_q [$];
   reg  [7:0]  exp_v;
   reg  [1:0]  upd_q [$];
   reg  [1:0]  upd_v;
   int         errors = 0;
   int         cmp_count = 0;
   // One-hot dow_onehot in shift order {dow, dd, mo, yy}
   reg  [31:0] cfg [0:6] = '{32'h40311299, 32'h01280204, 32'h02280203,
      32'h04290208, 32'h08300401, 32'h10300101, 32'h20310701};
   reg  [31:0] res [0:6] = '{32'h01010100, 32'h02290204, 32'h04010303,
      32'h08010308, 32'h10010501, 32'h20310101, 32'h40010801};
   reg  [9:0]  r;
   reg  [7:0]  ss;
   integer     i;

   clock_calendar_counters #(.OSC_DIV_N(DIV)) clock_calendar_counters_inst (
      .clk(clk), .nrst(nrst), .osc_tick(osc_tick), .count_halt(count_halt),
      .counter_select_decimal(counter_select_decimal),
      .frac_adjust_hi(frac_adjust_hi), .frac_adjust_lo(frac_adjust_lo),
      .frac_adjust_apply(frac_adjust_apply), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .buffer_capture(buffer_capture),
      .buffer_commit(buffer_commit), .sec_updated(sec_updated),
      .min_updated(min_updated), .hour_updated(hour_updated));
   osc_source #(.PERIOD(3)) osc_source_inst (
      .clk(clk), .nrst(nrst), .en(osc_en), .osc_tick(osc_tick));

   initial begin
      forever #10 clk = ~clk;
   end

   // ---------
   // Drivers
   // ---------
   task tick;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         tick;
         reg_wr = 1'b0;
         tick;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         exp_q.push_back(e);
         reg_addr = a;
         reg_rd = 1'b1;
         tick;
         reg_rd = 1'b0;
         tick;
      end
   endtask
   // Strobe: 0 capture, 1 commit, 2 offset apply
   task pulse(input integer k);
      begin
         buffer_capture = (k == 0);
         buffer_commit = (k == 1);
         frac_adjust_apply = (k == 2);
         tick;
         buffer_capture = 1'b0;
         buffer_commit = 1'b0;
         frac_adjust_apply = 1'b0;
         tick;
      end
   endtask
   // Count n ticks, or with n of 0 run until the seconds carry
   task run_osc(input integer n);
      integer t;
      integer k;
      begin
         k = 0;
         osc_en = 1'b1;
         for (t = 0; t < 2000 && (n ? k < n : k == 0); t = t + 1) begin
            @(posedge clk);
            if (n ? osc_tick === 1'b1 : sec_updated === 1'b1)
               k = k + 1;
         end
         #1;
         osc_en = 1'b0;
         if (t == 2000) begin
            errors = errors + 1;
            close_out;
         end
         tick;
         tick;
      end
   endtask
   task close_out;
      begin
         if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // ---------
   // Read monitor
   // ---------
   always @(posedge clk) begin
      if (rd_seen) begin
         exp_v = exp_q.pop_front();
         cmp_count = cmp_count + 1;
         if (reg_rdata !== exp_v) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, reg_rdata, exp_v);
         end
      end
      if (sec_updated === 1'b1 && upd_q.size() > 0) begin
         upd_v = upd_q.pop_front();
         cmp_count = cmp_count + 1;
         if ({hour_updated, min_updated} !== upd_v) begin
            errors = errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time,
                     {hour_updated, min_updated}, upd_v);
         end
      end
      rd_seen <= reg_rd;
   end

   // ---------
   // Scenarios
   // ---------
   initial begin
      void'($urandom(259));
      repeat (20) @(posedge clk);
      #1;
      nrst = 1'b1;
      tick;
      run_osc(3 * DIV);
      pulse(0);
      rd(8'h10, 8'h03);
      rd(8'h11, 8'h00);
      for (i = 0; i < 7; i = i + 1) begin
         rd(i[7:0], (i >= 3 && i <= 5) ? 8'h01 : 8'h00);
         rd(i[7:0] + 8'h12, (i >= 3 && i <= 5) ? 8'h01 : 8'h00);
      end
      rd(8'h07, 8'h00);
      rd(8'h20, 8'h00);
      for (i = 0; i < 7; i = i + 1) begin
         wr(8'h12, 8'h59);
         wr(8'h13, 8'h59);
         wr(8'h02, 8'h23);
         wr(8'h03, cfg[i][31:24]);
         wr(8'h04, cfg[i][23:16]);
         wr(8'h05, cfg[i][15:8]);
         wr(8'h06, cfg[i][7:0]);
         wr(8'h10, 8'hFF);
         wr(8'h11, 8'h03);
         pulse(1);
         count_halt = 1'b1;
         run_osc(2 * DIV);
         pulse(0);
         rd(8'h00, 8'h59);
         count_halt = 1'b0;
         upd_q.push_back(2'b11);
         run_osc(0);
         pulse(0);
         rd(8'h00, 8'h00);
         rd(8'h01, 8'h00);
         rd(8'h14, 8'h00);
         rd(8'h15, res[i][31:24]);
         rd(8'h16, res[i][23:16]);
         rd(8'h17, res[i][15:8]);
         rd(8'h18, res[i][7:0]);
         rd(8'h10, 8'h00);
      end
      r = 10'($urandom_range(1023, 1));
      frac_adjust_lo = r[7:0];
      frac_adjust_hi = {6'h00, r[9:8]};
      count_halt = 1'b1;
      pulse(2);
      pulse(0);
      rd(8'h10, 8'h00);
      count_halt = 1'b0;
      pulse(2);
      pulse(0);
      rd(8'h10, r[7:0]);
      rd(8'h11, {6'h00, r[9:8]});
      ss = 8'(($urandom % 6) * 16 + $urandom % 10);
      wr(8'h00, ss);
      pulse(1);
      pulse(0);
      rd(8'h00, ss);
      rd(8'h10, 8'h00);
      rd(8'h11, 8'h00);
      counter_select_decimal = 1'b0;
      pulse(0);
      rd(8'h00, 8'h07);
      rd(8'h01, 8'h00);
      rd(8'h04, 8'h00);
      counter_select_decimal = 1'b1;
      tick;
      close_out;
   end
endmodule // clock_calendar_counters_tb
